// *** pkg/rdc_pkg.sv ***
// Constants, modes and register map of the RS-485 driver enable control
// ****************************************************************
// ****************************************************************
package rdc_pkg;
    // Clock and bit rates
    localparam int CLK_HZ      = 20_000_000;
    localparam int RATE_MIN    = 1200;
    localparam int RATE_LO     = 38400;
    localparam int RATE_MID    = 57600;
    localparam int RATE_MAX    = 115200;
    localparam int BIT_MAX_DEF = CLK_HZ / RATE_MIN;
    localparam int BIT_LO_CYC  = CLK_HZ / RATE_LO;
    localparam int BIT_MID_CYC = CLK_HZ / RATE_MID;
    localparam int BIT_MIN_CYC = CLK_HZ / RATE_MAX;
    localparam int GLITCH_CYC  = BIT_MIN_CYC / 2;
    // Character and turnaround figures, in bit times
    localparam int CHAR_BITS   = 10;
    localparam int TURN_LO     = 4;
    localparam int TURN_MID    = 10;
    localparam int TURN_HI     = 20;
    // Widths
    localparam int PER_W       = 16;
    localparam int TAIL_W      = 5;
    localparam int ADDR_W      = 4;
    localparam int LOG_DEPTH   = 32;
    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_BITPER = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_TAIL   = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_LOG    = 4'hC;
    // Reset values
    localparam logic [TAIL_W-1:0] TAIL_RST   = 5'h01;

    // Driver control modes, in switch code order
    typedef enum logic [1:0] {
        MODE_FULL, MODE_AUTO, MODE_RTS, MODE_DATA
    } rdc_mode_e;

    // Automatic mode frame tracking
    typedef enum logic [1:0] {
        A_IDLE, A_BITS, A_TAIL
    } rdc_auto_e;

    // Largest turnaround allowed for a measured bit period
    function automatic logic [TAIL_W-1:0] tail_limit(
        input logic [PER_W-1:0] per);
        if (per >= PER_W'(BIT_LO_CYC)) begin
            tail_limit = TAIL_W'(TURN_LO);
        end else if (per >= PER_W'(BIT_MID_CYC)) begin
            tail_limit = TAIL_W'(TURN_MID);
        end else begin
            tail_limit = TAIL_W'(TURN_HI);
        end
    endfunction : tail_limit
endpackage : rdc_pkg

// *** pkg/rdc_fifo_if.sv ***
// Valid/ready interface between the pulse logger and its FIFO
`timescale 1ns/1ns
interface rdc_fifo_if #(parameter int W = 16);
    logic         wr_valid;
    logic         wr_ready;
    logic [W-1:0] wr_data;
    logic         rd_valid;
    logic         rd_ready;
    logic [W-1:0] rd_data;
    modport fill  (output wr_valid, wr_data, input wr_ready,
                   input rd_valid, rd_data, output rd_ready);
    modport fifo  (input wr_valid, wr_data, output wr_ready,
                   output rd_valid, rd_data, input rd_ready);
endinterface : rdc_fifo_if

// *** logic/rdc_fifo.sv ***
// Parameterised FIFO with a registered output word
`timescale 1ns/1ns
module rdc_fifo
    import rdc_pkg::*;
#(
    parameter int W     = PER_W,
    parameter int DEPTH = LOG_DEPTH
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic SRST,
    // Both sides
    rdc_fifo_if.fifo f
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wptr;
        logic [PW-1:0]           rptr;
        logic [CW-1:0]           cnt;
        logic                    out_v;
        logic [W-1:0]            out_d;
    } rdc_fifo_s;

    rdc_fifo_s s;
    rdc_fifo_s next_s;
    logic      take;

    assign f.wr_ready = (s.cnt != CW'(DEPTH));
    assign f.rd_valid = s.out_v;
    assign f.rd_data  = s.out_d;

    // Store, then refill the output word when it is empty or drained
    always_comb begin
        next_s = s;
        take   = f.rd_ready && s.out_v;
        if (f.wr_valid && f.wr_ready) begin
            next_s.mem[s.wptr] = f.wr_data;
            next_s.wptr        = s.wptr + 1'b1;
            next_s.cnt         = next_s.cnt + 1'b1;
        end
        if (take) begin
            next_s.out_v = 1'b0;
        end
        if ((!s.out_v || take) && s.cnt != '0) begin
            next_s.out_d = s.mem[s.rptr];
            next_s.out_v = 1'b1;
            next_s.rptr  = s.rptr + 1'b1;
            next_s.cnt   = next_s.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    a_fifo_bound: assert property (@(posedge MCLK) disable iff (SRST)
        s.cnt <= CW'(DEPTH))
        else $error("FIFO count above depth");
endmodule : rdc_fifo

// *** logic/rdc_top.sv ***
// RS-485 line driver enable and echo control with APB registers
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ns
module rdc_top
    import rdc_pkg::*;
#(
    parameter int BIT_MAX_CYC = BIT_MAX_DEF
) (
    // Clock and reset
    input  wire logic              MCLK,
    input  wire logic              SRST,
    // APB slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // Host UART side
    input  wire logic              TXD_IN,
    input  wire logic              RTS_IN,
    output logic                   RXD_OUT,
    // Line transceiver side
    output logic                   LINE_TXD,
    output logic                   LINE_DE_N,
    input  wire logic              LINE_RXD,
    // Switches
    input  wire logic [1:0]        MODE_SELECT_SWITCH,
    input  wire logic              ECHO_OFF
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic              sampled;
        rdc_mode_e         mode;
        logic              txd_q;
        rdc_auto_e         ast;
        logic [PER_W-1:0]  cyc;
        logic [3:0]        bitn;
        logic [TAIL_W-1:0] tleft;
        logic [PER_W-1:0]  run;
        logic [PER_W-1:0]  bit_per;
        logic              locked;
        logic              drive;
        logic              de_n;
        logic              line_txd;
        logic              rxd_out;
        logic [TAIL_W-1:0] tail;
        logic              pend;
        logic [PER_W-1:0]  pend_d;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } rdc_top_s;

    rdc_top_s          st;
    rdc_top_s          next_st;
    logic              fell;
    logic              rose;
    logic              bit_end;
    logic              d;
    logic [TAIL_W-1:0] lim;
    logic [TAIL_W-1:0] tail_use;

    rdc_fifo_if #(.W(PER_W)) log_if ();

    // ****************************************************************
    // Pulse width log
    // ****************************************************************
    rdc_fifo #(
        .W     (PER_W),
        .DEPTH (LOG_DEPTH)
    ) u_log (
        .MCLK (MCLK),
        .SRST (SRST),
        .f    (log_if.fifo)
    );

    assign log_if.wr_valid = st.pend;
    assign log_if.wr_data  = st.pend_d;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st  = st;
        fell     = st.txd_q && !TXD_IN;
        rose     = !st.txd_q && TXD_IN;
        bit_end  = (st.cyc >= st.bit_per - 1'b1);
        lim      = tail_limit(st.bit_per);
        tail_use = (st.tail > lim) ? lim : st.tail;
        d        = 1'b0;
        log_if.rd_ready = 1'b0;
        next_st.txd_q   = TXD_IN;

        // Mode switch is taken once, on the first cycle after reset
        if (!st.sampled) begin
            next_st.sampled = 1'b1;
            next_st.mode    = rdc_mode_e'(MODE_SELECT_SWITCH);
        end

        // Low run width; the shortest plausible one is the bit period
        if (!TXD_IN) begin
            if (st.run != '1) begin
                next_st.run = st.run + 1'b1;
            end
        end else begin
            next_st.run = '0;
        end
        if (rose && st.run >= PER_W'(GLITCH_CYC)) begin
            if (st.run < st.bit_per) begin
                next_st.bit_per = (st.run < PER_W'(BIT_MIN_CYC)) ?
                                  PER_W'(BIT_MIN_CYC) : st.run;
            end
            next_st.locked = 1'b1;
        end

        // Logger hands widths to the FIFO; a full FIFO stalls it
        if (st.pend && log_if.wr_ready) begin
            next_st.pend = 1'b0;
        end
        if (rose && (!st.pend || log_if.wr_ready)) begin
            next_st.pend   = 1'b1;
            next_st.pend_d = st.run;
        end

        // Automatic mode frame tracking
        case (st.ast)
            A_IDLE: begin
                if (fell) begin
                    next_st.ast  = A_BITS;
                    next_st.cyc  = '0;
                    next_st.bitn = '0;
                end
            end
            A_BITS: begin
                next_st.cyc = st.cyc + 1'b1;
                if (bit_end) begin
                    next_st.cyc  = '0;
                    next_st.bitn = st.bitn + 1'b1;
                    if (st.bitn == 4'(CHAR_BITS - 1)) begin
                        // Stop bit done: hold for the turnaround time
                        next_st.tleft = tail_use;
                        next_st.ast   = (tail_use == '0) ? A_IDLE : A_TAIL;
                    end
                end
            end
            A_TAIL: begin
                next_st.cyc = st.cyc + 1'b1;
                if (fell) begin
                    next_st.ast  = A_BITS;
                    next_st.cyc  = '0;
                    next_st.bitn = '0;
                end else if (bit_end) begin
                    next_st.cyc   = '0;
                    next_st.tleft = st.tleft - 1'b1;
                    if (st.tleft == TAIL_W'(1)) begin
                        next_st.ast = A_IDLE;
                    end
                end
            end
            default: begin
                next_st.ast = A_IDLE;
            end
        endcase

        // Driver enable by mode; off until the switch is taken
        case (next_st.mode)
            MODE_FULL: d = 1'b1;
            MODE_AUTO: d = (next_st.ast != A_IDLE);
            MODE_RTS:  d = RTS_IN;
            MODE_DATA: d = !TXD_IN;
            default:   d = 1'b0;
        endcase
        if (!next_st.sampled || !st.sampled) begin
            d = 1'b0;
        end
        next_st.drive    = d;
        next_st.de_n     = !d;
        next_st.line_txd = TXD_IN;
        // Echo control of the host receive path
        next_st.rxd_out  = (ECHO_OFF && d) ? 1'b1 : LINE_RXD;

        // APB slave: one wait state, answer from registers
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        if (PSEL && PENABLE && !st.pready) begin
            next_st.pready = 1'b1;
            next_st.prdata = '0;
            case (PADDR)
                OFF_STATUS: begin
                    next_st.prdata = 32'({log_if.rd_valid, st.locked,
                                          st.drive, ECHO_OFF, st.mode});
                end
                OFF_BITPER: begin
                    next_st.prdata = 32'(st.bit_per);
                end
                OFF_TAIL: begin
                    next_st.prdata = 32'(st.tail);
                    if (PWRITE) begin
                        next_st.tail = PWDATA[TAIL_W-1:0];
                    end
                end
                OFF_LOG: begin
                    if (!PWRITE) begin
                        next_st.prdata = {log_if.rd_valid, 15'h0000,
                                          log_if.rd_data};
                        log_if.rd_ready = 1'b1;
                    end
                end
                default: begin
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            st          <= '0;
            st.txd_q    <= 1'b1;
            st.bit_per  <= PER_W'(BIT_MAX_CYC);
            st.tail     <= TAIL_RST;
            st.de_n     <= 1'b1;
            st.line_txd <= 1'b1;
            st.rxd_out  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign PRDATA    = st.prdata;
    assign PREADY    = st.pready;
    assign PSLVERR   = st.pslverr;
    assign RXD_OUT   = st.rxd_out;
    assign LINE_TXD  = st.line_txd;
    assign LINE_DE_N = st.de_n;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_full_always_on: assert property (@(posedge MCLK) disable iff (SRST)
        st.sampled && st.mode == MODE_FULL |=> st.drive [*2])
        else $error("Full-duplex driver dropped");

    a_default_full: assert property (@(posedge MCLK) disable iff (SRST)
        !st.sampled |-> st.mode == MODE_FULL)
        else $error("Mode not full-duplex before sampling");

    a_auto_follow: assert property (@(posedge MCLK) disable iff (SRST)
        st.mode == MODE_AUTO && $past(st.sampled)
        |-> st.drive == (st.ast != A_IDLE))
        else $error("Auto enable not tied to frame state");

    a_tail_bound: assert property (@(posedge MCLK) disable iff (SRST)
        st.ast == A_TAIL |-> st.tleft <= tail_limit(st.bit_per))
        else $error("Turnaround longer than allowed");

    a_rate_floor: assert property (@(posedge MCLK) disable iff (SRST)
        st.bit_per >= PER_W'(BIT_MIN_CYC))
        else $error("Bit period below fastest rate");

    a_rts_follow: assert property (@(posedge MCLK) disable iff (SRST)
        st.sampled && st.mode == MODE_RTS |=> st.drive == $past(RTS_IN))
        else $error("Driver does not follow RTS");

    a_data_high_off: assert property (@(posedge MCLK) disable iff (SRST)
        st.sampled && st.mode == MODE_DATA && TXD_IN
        |=> !st.drive && st.line_txd)
        else $error("Driver on for a high data bit");

    a_data_low_on: assert property (@(posedge MCLK) disable iff (SRST)
        st.sampled && st.mode == MODE_DATA && !TXD_IN
        |=> st.drive && !LINE_DE_N)
        else $error("Driver off for a low data bit");

    a_off_unsampled: assert property (@(posedge MCLK) disable iff (SRST)
        !st.sampled |-> LINE_DE_N)
        else $error("Driver on before mode is known");

    a_echo_pass: assert property (@(posedge MCLK) disable iff (SRST)
        !SRST && !ECHO_OFF |=> RXD_OUT == $past(LINE_RXD))
        else $error("Receive path not passed through");

    a_echo_block: assert property (@(posedge MCLK) disable iff (SRST)
        ECHO_OFF ##1 st.drive |-> RXD_OUT)
        else $error("Own transmission echoed");

    a_mode_frozen: assert property (@(posedge MCLK) disable iff (SRST)
        st.sampled |=> $stable(st.mode))
        else $error("Mode changed after sampling");

    a_auto_start: assert property (@(posedge MCLK) disable iff (SRST)
        st.sampled && st.mode == MODE_AUTO && st.ast == A_IDLE && fell
        |=> st.drive && !LINE_TXD)
        else $error("Start bit not driven");

    a_apb_wait: assert property (@(posedge MCLK) disable iff (SRST)
        PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
        else $error("APB answer not one wait state");
endmodule : rdc_top

// *** dv/rdc_host.sv ***
// Host UART model: framed transmit data and RTS level
`timescale 1ns/1ns
module rdc_host (
    // Clock
    input  wire logic        MCLK,
    // Bench commands
    input  wire logic        go,
    input  wire logic [7:0]  tx_byte,
    input  wire logic [15:0] bit_cyc,
    input  wire logic        raw_bit,
    input  wire logic        rts_req,
    // Host pins
    output logic             txd,
    output logic             rts,
    output logic             busy
);
    // ****************************************************************
    // Character framer
    // ****************************************************************
    logic [9:0]  frame;
    logic [3:0]  nbit;
    logic [15:0] cnt;

    initial begin
        txd = 1'b1;
        rts = 1'b0;
        busy = 1'b0;
    end

    // Start, eight data bits LSB first, stop; each bit_cyc cycles long
    always @(posedge MCLK) begin
        rts <= rts_req;
        if (!busy) begin
            txd <= raw_bit;
            if (go) begin
                frame <= {1'b1, tx_byte, 1'b0};
                busy <= 1'b1;
                cnt <= 16'h0000;
                nbit <= 4'h0;
                txd <= 1'b0;
            end
        end else if (cnt == bit_cyc - 16'h0001) begin
            cnt <= 16'h0000;
            if (nbit == 4'h9) begin
                busy <= 1'b0;
                txd <= raw_bit;
            end else begin
                nbit <= nbit + 4'h1;
                txd <= frame[nbit + 4'h1];
            end
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end
endmodule : rdc_host

// *** dv/testbench.sv ***
// Self-checking bench for the RS-485 driver enable control
`timescale 1ns/1ns
module testbench;
    import rdc_pkg::*;
    // ****************************************************************
    // Signals, models and checking
    // ****************************************************************
    localparam int BMAX = 400;
    localparam int BIT  = 200;
    logic              mclk = 1'b0;
    logic              srst = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 4'h0;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata;
    logic              pready, pslverr, txd, rts, rxd_out;
    logic              line_txd, line_de_n, busy;
    logic              line_rxd = 1'b1;
    logic              echo_off = 1'b0;
    logic              go = 1'b0;
    logic              raw_bit = 1'b1;
    logic              rts_req = 1'b0;
    logic              look = 1'b0;
    logic              clr = 1'b0;
    logic [1:0]        mode_sw = 2'h0;
    logic [31:0]       seed = 32'h6519;
    logic [65:0]       apb_q[$];
    logic [5:0]        line_q[$];
    logic [65:0]       ae;
    logic [5:0]        le;
    int                failures = 0;
    int                comparisons = 0;
    int                lowcnt = 0;

    // Clock at 20 MHz
    always #25 mclk = ~mclk;

    rdc_top #(.BIT_MAX_CYC(BMAX)) u_dut (
        .MCLK(mclk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .TXD_IN(txd), .RTS_IN(rts),
        .RXD_OUT(rxd_out), .LINE_TXD(line_txd), .LINE_DE_N(line_de_n),
        .LINE_RXD(line_rxd), .MODE_SELECT_SWITCH(mode_sw),
        .ECHO_OFF(echo_off));

    rdc_host u_host (
        .MCLK(mclk), .go(go), .tx_byte(8'h55), .bit_cyc(16'(BIT)),
        .raw_bit(raw_bit), .rts_req(rts_req), .txd(txd), .rts(rts),
        .busy(busy));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    task automatic cmp(input logic [32:0] got, exp, m);
        comparisons++;
        if ((got & m) !== (exp & m)) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got & m, exp & m);
        end
    endtask : cmp

    // Monitor takes the oldest note whenever a result shows
    always @(posedge mclk) begin
        if (pready && apb_q.size() > 0) begin
            ae = apb_q.pop_front();
            cmp({pslverr, prdata}, ae[65:33], ae[32:0]);
        end
        if (look && line_q.size() > 0) begin
            le = line_q.pop_front();
            cmp({30'h0, line_de_n, rxd_out, line_txd}, {30'h0, le[5:3]},
                {30'h0, le[2:0]});
        end
    end

    // Counts driving cycles of one character
    always @(posedge mclk) begin
        if (clr) begin
            lowcnt <= 0;
        end else if (!line_de_n) begin
            lowcnt <= lowcnt + 1;
        end
    end

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d, input logic [32:0] e, m);
        apb_q.push_back({e, m});
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Hold the request until ready is seen; the watchdog ends a hang
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic lchk(input logic [2:0] e, m);
        repeat (3) @(posedge mclk);
        line_q.push_back({e, m});
        look <= 1'b1;
        @(posedge mclk);
        look <= 1'b0;
    endtask : lchk

    task automatic rst(input logic [1:0] md);
        srst <= 1'b1;
        mode_sw <= md;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : rst

    task automatic send;
        int n;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        lchk(3'b000, 3'b101);
        for (n = 0; n < 3000 && busy; n++) @(posedge mclk);
    endtask : send

    task automatic complete_run;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    // Watchdog against a hang
    initial begin
        repeat (90000) @(posedge mclk);
        failures++;
        complete_run();
    end

    initial begin
        // Full duplex: switch changes are ignored; driver stays on while data passes through
        rst(2'h0);
        mode_sw <= 2'h2;
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            raw_bit <= seed[0];
            line_rxd <= seed[1];
            lchk({1'b0, seed[1], seed[0]}, 3'b111);
        end
        apb(1'b0, OFF_STATUS, 32'h0, 33'h0, 33'h1_0000_0007);
        apb(1'b0, OFF_TAIL, 32'h0, 33'h1, 33'h1_0000_001F);
        apb(1'b0, 4'h1, 32'h0, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
        echo_off <= 1'b1;
        line_rxd <= 1'b0;
        lchk(3'b010, 3'b110);
        // RTS mode
        rst(2'h2);
        lchk(3'b100, 3'b110);
        rts_req <= 1'b1;
        lchk(3'b010, 3'b110);
        echo_off <= 1'b0;
        lchk(3'b000, 3'b110);
        apb(1'b0, OFF_STATUS, 32'h0, 33'h2, 33'h1_0000_0007);
        // Data enable mode with random bits
        rst(2'h3);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            raw_bit <= seed[0];
            lchk({seed[0], 1'b0, seed[0]}, 3'b101);
        end
        // Automatic mode near the top bit rate; line idles high from reset
        raw_bit <= 1'b1;
        rts_req <= 1'b0;
        rst(2'h1);
        lchk(3'b100, 3'b100);
        apb(1'b1, OFF_TAIL, 32'h3, 33'h0, 33'h1_0000_0000);
        apb(1'b0, OFF_TAIL, 32'h0, 33'h3, 33'h1_0000_001F);
        for (int i = 0; i < 7; i++) begin
            if (i == 6) clr <= 1'b1;
            @(posedge mclk);
            clr <= 1'b0;
            send();
            repeat (4 * BIT) @(posedge mclk);
        end
        repeat (17 * BIT) @(posedge mclk);
        cmp({32'h0, lowcnt >= 10 * BIT && lowcnt <= 13 * BIT + 4},
            33'h1, 33'h1);
        apb(1'b0, OFF_BITPER, 32'h0, 33'(BIT), 33'h1_0000_FFFF);
        apb(1'b0, OFF_STATUS, 32'h0, 33'h1, 33'h1_0000_0003);
        // 35 low runs: 32 FIFO words, output word and pending word kept
        for (int i = 0; i < 34; i++) begin
            apb(1'b0, OFF_LOG, 32'h0, {1'b0, 1'b1, 15'h0, 16'(BIT)},
                33'h1_8000_FFFF);
        end
        apb(1'b0, OFF_LOG, 32'h0, 33'h0, 33'h1_8000_0000);
        complete_run();
    end
endmodule : testbench
